/* core/tws_pkg.sv */
/*
 File holds the shared constants and types of the three-wire control slave.
 Assumes a single system clock domain; link pins are sampled, not clocked.
*/
package tws_pkg;

   // Device identity on the link, byte bits 7..2 (time order 0,1,1,0,0,0)
   localparam logic [5:0] DEV_ADDR      = 6'h06;

   // Transfer type field, {bit1, bit0}
   localparam logic [1:0] TT_WRITE      = 2'h2;
   localparam logic [1:0] TT_READ       = 2'h3;

   // Byte framing
   localparam logic [2:0] LAST_BIT      = 3'h7;
   localparam logic [1:0] BYTE_REG      = 2'h0;
   localparam logic [1:0] BYTE_HI       = 2'h1;
   localparam logic [1:0] BYTE_LO       = 2'h2;
   localparam logic [1:0] BYTE_DONE     = 2'h3;

   // Reset values of the sampled pin levels
   localparam logic [2:0] PIN_RST       = 3'h0;

   // Selection state, one-hot
   typedef enum logic [2:0] {
      TWS_IDLE  = 3'b001,
      TWS_WRITE = 3'b010,
      TWS_READ  = 3'b100
   } tws_state_e;

endpackage

/* core/tws_slave.sv */
/*
 File holds the serial control-port slave: address mode, write and read.
 Assumes the link pins come from another domain and the register store
 sits outside, answering rd_addr combinationally on the same clock.
*/
`timescale 1ns/1ps

// Function
// [RULE1] Bytes shift least significant bit first
// [RULE2] Mode low: eight pulses carry address byte
// [RULE3] Mode high: register, instruction or data bytes
// [RULE4] Address byte selects participation in data bytes
// [RULE5] Host wakes port with one pulse first
// [RULE6] Bits 0-1 transfer type, 2-7 address
// [RULE7] Type 01 write, 11 read, others ignored
// [RULE8] Respond only to own six-bit address
// [RULE9] Register byte: bit0 direction, then address MSB-first
// [RULE10] Write is four bytes ending in data
// [RULE11] Data word upper byte first, MSB first
// [RULE12] Host resends address for each register
// [RULE13] Read is six bytes, three device driven
// [RULE14] Read type makes device drive data line
// [RULE15] Echo address, bit0 flags invalid register
// [RULE16] Then register contents, upper byte first
// [RULE17] Port active only with style select low
// [RULE18] Sample on rising, change after falling edge
// [RULE19] Data line released except three response bytes
module tws_slave #(
   parameter logic [5:0] OWN_ADDR = tws_pkg::DEV_ADDR
) (
   // System
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Link pins
   input  wire logic        ctrl_clock_line,
   input  wire logic        ctrl_mode_line,
   input  wire logic        ctrl_data_in,
   output logic             ctrl_data_out,
   output logic             ctrl_data_oe_n,
   // Strap
   input  wire logic        control_style_select,
   // Register write side
   output logic             wr_strobe,
   output logic      [6:0]  wr_addr,
   output logic      [15:0] wr_data,
   // Register read side
   output logic      [6:0]  rd_addr,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid
);

   typedef struct packed {
      logic                clk_prev;
      logic                mode_prev;
      logic [2:0]          bit_cnt;
      logic [1:0]          byte_idx;
      logic [7:0]          shift;
      tws_pkg::tws_state_e state;
      logic                prep;
      logic [6:0]          reg_addr;
      logic [7:0]          data_hi;
      logic [15:0]         rd_word;
      logic                rd_ok;
      logic                wr_strobe;
      logic [6:0]          wr_addr;
      logic [15:0]         wr_data;
      logic                drive;
      logic                dout;
   } tws_slave_s;

   tws_slave_s st_reg;
   tws_slave_s st_next;

   logic [2:0]  lvl;
   logic        clk_s;
   logic        mode_s;
   logic        data_s;
   logic        active;
   logic        rise;
   logic        fall;
   logic        mode_chg;
   logic        byte_done;
   logic [7:0]  byte_val;
   logic [23:0] tx_vec;
   logic [4:0]  tx_idx;
   logic [7:0]  echo_t;
   logic        control_style_sync;

   // The three link pins pass the three-flop filter together; the strap has its own filter
   tws_sync #(
      .W       (3),
      .RST_VAL (tws_pkg::PIN_RST)
   ) u_sync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin_in  ({ctrl_clock_line, ctrl_mode_line, ctrl_data_in}),
      .level   (lvl)
   );

   // Settled pin levels and their events
   always_comb
   begin
      clk_s     = lvl[2];
      mode_s    = lvl[1];
      data_s    = lvl[0];
      active    = ~control_style_sync;
      rise      = clk_s & ~st_reg.clk_prev;
      fall      = ~clk_s & st_reg.clk_prev;
      mode_chg  = mode_s ^ st_reg.mode_prev;
      byte_val  = {data_s, st_reg.shift[7:1]};
      byte_done = active & rise & ~mode_chg & (st_reg.bit_cnt == tws_pkg::LAST_BIT);
   end

   // Strap is static but still comes from a pin, so it is filtered too
   tws_sync #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_strap (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin_in  (control_style_select),
      .level   (control_style_sync)
   );

   // Bits 7..1 of a byte in time order hold the address MSB first
   function automatic logic [6:0] addr_of(input logic [7:0] b);
      logic [6:0] r;
      r = '0;
      for (int i = 0; i < 7; i++)
      begin
         r[6 - i] = b[i + 1];
      end
      return r;
   endfunction

   // Byte in time order to data value, earliest bit is the MSB
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
      begin
         r[7 - i] = b[i];
      end
      return r;
   endfunction

   // Response stream: echo, upper data byte, lower data byte, time order
   // [RULE15] echo with invalid flag
   // [RULE16] data upper byte next
   always_comb
   begin
      echo_t        = rev8({1'b0, st_reg.reg_addr});
      tx_vec[0]     = ~st_reg.rd_ok;
      tx_vec[7:1]   = echo_t[7:1];
      tx_vec[15:8]  = rev8(st_reg.rd_word[15:8]);
      tx_vec[23:16] = rev8(st_reg.rd_word[7:0]);
      // Falls before data mode settles point at the first echo bit
      tx_idx        = st_reg.mode_prev ? {st_reg.byte_idx, st_reg.bit_cnt} : 5'h00;
   end

   // Next-state logic
   always_comb
   begin
      st_next           = st_reg;
      st_next.clk_prev  = clk_s;
      st_next.mode_prev = mode_s;
      st_next.wr_strobe = 1'b0;
      if (!active)
      begin
         // [RULE17] port held idle
         st_next.state    = tws_pkg::TWS_IDLE;
         st_next.bit_cnt  = '0;
         st_next.byte_idx = '0;
         st_next.dout     = 1'b0;
      end
      else
      begin
         if (mode_chg)
         begin
            // [RULE3] mode edge frames bytes
            st_next.bit_cnt  = '0;
            st_next.byte_idx = '0;
         end
         else if (rise)
         begin
            // [RULE1] LSB arrives first
            st_next.shift   = byte_val;
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            if (byte_done && st_reg.byte_idx != tws_pkg::BYTE_DONE)
            begin
               st_next.byte_idx = st_reg.byte_idx + 2'h1;
            end
         end
         if (byte_done && !mode_s)
         begin
            // [RULE2] address byte complete
            // [RULE6] field split of address byte
            if (byte_val[7:2] == OWN_ADDR && byte_val[1:0] == tws_pkg::TT_READ)
            begin
               // [RULE14] read selection latches word
               st_next.state   = tws_pkg::TWS_READ;
               st_next.rd_word = rd_data;
               st_next.rd_ok   = rd_valid;
            end
            else if (byte_val[7:2] == OWN_ADDR && byte_val[1:0] == tws_pkg::TT_WRITE)
            begin
               st_next.state = tws_pkg::TWS_WRITE;
            end
            else
            begin
               // [RULE7] unused types ignored
               // [RULE8] other addresses deselect
               st_next.state = tws_pkg::TWS_IDLE;
            end
         end
         else if (byte_done && st_reg.state == tws_pkg::TWS_WRITE)
         begin
            // [RULE4] only selected device takes bytes
            case (st_reg.byte_idx)
               tws_pkg::BYTE_REG:
               begin
                  // [RULE9] direction flag and address
                  st_next.prep     = byte_val[0];
                  st_next.reg_addr = addr_of(byte_val);
               end
               tws_pkg::BYTE_HI:
               begin
                  // [RULE11] upper byte first
                  st_next.data_hi = rev8(byte_val);
               end
               tws_pkg::BYTE_LO:
               begin
                  // [RULE10] fourth byte completes write
                  if (!st_reg.prep)
                  begin
                     st_next.wr_strobe = 1'b1;
                     st_next.wr_addr   = st_reg.reg_addr;
                     st_next.wr_data   = {st_reg.data_hi, rev8(byte_val)};
                  end
               end
               default:
               begin
                  st_next.state = st_reg.state;
               end
            endcase
         end
         if (fall)
         begin
            // [RULE18] change after falling edge
            st_next.dout = (tx_idx < 5'd24) ? tx_vec[tx_idx] : 1'b0;
         end
      end
      // [RULE19] drive only the three response bytes
      // [RULE13] response length of three bytes
      st_next.drive = active & mode_s & (st_reg.state == tws_pkg::TWS_READ) &
                      (st_reg.byte_idx != tws_pkg::BYTE_DONE);
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_reg       <= '0;
         st_reg.state <= tws_pkg::TWS_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flops
   assign ctrl_data_out  = st_reg.dout;
   assign ctrl_data_oe_n = ~st_reg.drive;
   assign wr_strobe      = st_reg.wr_strobe;
   assign wr_addr        = st_reg.wr_addr;
   assign wr_data        = st_reg.wr_data;
   assign rd_addr        = st_reg.reg_addr;

   // Checks on the design's own behaviour
   sequence own_read_byte;
      byte_done && !mode_s && byte_val[7:2] == OWN_ADDR &&
      byte_val[1:0] == tws_pkg::TT_READ;
   endsequence

   sequence unused_byte;
      byte_done && !mode_s && !byte_val[1];
   endsequence

   sequence echo_first_fall;
      active && fall && st_reg.state == tws_pkg::TWS_READ && !st_reg.mode_prev;
   endsequence

   read_select_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
      own_read_byte |=> st_reg.state == tws_pkg::TWS_READ && st_reg.rd_word == $past(rd_data))
      else $error("read selection not taken");

   unused_type_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE7
      unused_byte |=> st_reg.state == tws_pkg::TWS_IDLE)
      else $error("unused transfer type selected device");

   write_end_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE10
      st_reg.wr_strobe |-> st_reg.byte_idx == tws_pkg::BYTE_DONE &&
      st_reg.state == tws_pkg::TWS_WRITE && !st_reg.prep ##1 !st_reg.wr_strobe)
      else $error("write strobe outside fourth byte");

   line_release_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE19
      !(mode_s && st_reg.state == tws_pkg::TWS_READ && st_reg.byte_idx != 2'h3)
      |=> ctrl_data_oe_n)
      else $error("data line driven outside response");

   lsb_shift_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
      active && rise && !mode_chg |=> st_reg.shift[7] == $past(data_s))
      else $error("bit not shifted in at top");

   echo_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE15
      echo_first_fall |=> ctrl_data_out == !$past(st_reg.rd_ok))
      else $error("echo flag wrong");

   upper_first_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
      active && fall && st_reg.state == tws_pkg::TWS_READ && st_reg.byte_idx == 2'h1 &&
      st_reg.bit_cnt == 3'h0 && st_reg.mode_prev
      |=> ctrl_data_out == $past(st_reg.rd_word[15]))
      else $error("data not upper bit first");

   style_off_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE17
      !active |=> st_reg.state == tws_pkg::TWS_IDLE ##1 ctrl_data_oe_n)
      else $error("port active with style select high");

   fall_change_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE18
      $changed(ctrl_data_out) |-> $past(fall) || $past(!active))
      else $error("data changed without falling edge");

endmodule

/* core/tws_slave_dummy_unused.sv */
/*
 File intentionally left minimal.
*/

/* core/tws_sync.sv */
/*
 File holds the pin synchroniser: three flops per pin and a settled level.
 Assumes asynchronous pin inputs and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tws_sync #(
   parameter int          W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // System
   input  wire logic         clock,
   input  wire logic         sys_rst,
   // Pins in
   input  wire logic [W-1:0] pin_in,
   // Settled levels out
   output logic      [W-1:0] level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } tws_sync_s;

   tws_sync_s st_reg;
   tws_sync_s st_next;

   // Level moves only once the second and third flops agree
   always_comb
   begin
      st_next     = st_reg;
      st_next.s1  = pin_in;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.lvl;

endmodule

/* tb/tb_tws_slave.sv */
/*
 Holds the self-checking bench of the control slave with a register store.
 Assumes the host model in tws_host and a 200 MHz system clock.
*/
`timescale 1ns/1ps
module tb_tws_slave;
   logic        clock;
   logic        sys_rst;
   logic        control_style_select;
   logic        ctrl_clock_line;
   logic        ctrl_mode_line;
   logic        host_data;
   logic        host_drive;
   logic        data_line;
   logic        last_line;
   logic        ctrl_data_out;
   logic        ctrl_data_oe_n;
   logic        wr_strobe;
   logic [6:0]  wr_addr;
   logic [15:0] wr_data;
   logic [6:0]  rd_addr;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic [15:0] mem [128];
   logic [22:0] exp_q [$];
   logic [31:0] lfsr_state;
   int          error_cnt;
   int          n_compared;

   // Clock
   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   // Wire level; a released line toggles so no stale value passes
   assign data_line = (ctrl_data_oe_n === 1'b0) ? ctrl_data_out
                    : host_drive ? host_data : ~last_line;
   always @(posedge clock) last_line <= data_line;

   // Register store; addresses ending in 11 are invalid
   assign rd_data  = mem[rd_addr];
   assign rd_valid = (rd_addr[1:0] != 2'b11);

   tws_slave u_dut (
      .clock(clock), .sys_rst(sys_rst),
      .ctrl_clock_line(ctrl_clock_line), .ctrl_mode_line(ctrl_mode_line),
      .ctrl_data_in(data_line), .ctrl_data_out(ctrl_data_out),
      .ctrl_data_oe_n(ctrl_data_oe_n), .control_style_select(control_style_select),
      .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

   tws_host u_host (
      .clock(clock), .ctrl_clock_line(ctrl_clock_line), .ctrl_mode_line(ctrl_mode_line),
      .host_data(host_data), .host_drive(host_drive), .data_line(data_line));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Bit order flip, since the link puts the top data bit first in time
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         rev8[i] = v[7 - i];
   endfunction

   task automatic check(input logic [22:0] seen, input logic [22:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic results();
      $display("Counts: %0d compared, %0d mismatched", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Each write strobe takes the oldest expectation off the queue; the
   // falling edge is used so the registered outputs have settled
   always @(negedge clock)
   begin
      if (wr_strobe === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(23'(0), 23'(1), "write with nothing pending");
         else
            check({wr_addr, wr_data}, exp_q.pop_front(), "write");
      end
      if (host_drive && ctrl_data_oe_n === 1'b0)
         check(23'(0), 23'(1), "line contention");
   end

   // Bounded wait for pending writes, then the line must be released
   task automatic drain(input string name);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      if (exp_q.size() != 0)
      begin
         check(23'(exp_q.size()), 23'(0), "write lost");
         results();
      end
      repeat (40) @(posedge clock);
      #1;
      check(23'(ctrl_data_oe_n), 23'(1), "line not released");
      $display("test %s done", name);
   endtask

   // Address byte, register byte, two data bytes
   task automatic write_reg(input logic [5:0] dev, input logic [1:0] tt,
                            input logic [6:0] a, input logic [15:0] d);
      u_host.send_byte(1'b0, {dev, tt});
      u_host.send_byte(1'b1, rev8({1'b0, a}));
      u_host.send_byte(1'b1, rev8(d[15:8]));
      u_host.send_byte(1'b1, rev8(d[7:0]));
   endtask

   // Whole timeout cut
   initial
   begin
      repeat (90000) @(posedge clock);
      check(23'(0), 23'(1), "timeout");
      results();
   end

   initial
   begin
      logic [6:0]  a;
      logic [15:0] d;
      logic [7:0]  e;
      logic [7:0]  h;
      logic [7:0]  l;
      sys_rst              = 1'b1;
      control_style_select = 1'b0;
      last_line            = 1'b0;
      error_cnt            = 0;
      n_compared           = 0;
      lfsr_state           = 32'h0000_47a1;
      for (int i = 0; i < 128; i++)
      begin
         lfsr_state = lfsr(lfsr_state);
         mem[i]     = lfsr_state[15:0];
      end
      repeat (10) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      u_host.wake();
      // Random writes, both end addresses included, back to back
      for (int i = 0; i < 4; i++)
      begin
         lfsr_state = lfsr(lfsr_state);
         a = (i == 0) ? 7'h00 : (i == 3) ? 7'h7f : lfsr_state[22:16];
         d = lfsr_state[15:0];
         exp_q.push_back({a, d});
         write_reg(tws_pkg::DEV_ADDR, tws_pkg::TT_WRITE, a, d);
      end
      drain("writes");
      // Foreign address, then both unused transfer types
      write_reg(tws_pkg::DEV_ADDR ^ 6'h20, tws_pkg::TT_WRITE, 7'h11, 16'h1234);
      for (int k = 0; k < 2; k++)
         write_reg(tws_pkg::DEV_ADDR, 2'(k), 7'h11, 16'h1234);
      drain("refused");
      // Prepare read, read selection, three returned bytes; valid then invalid
      for (int k = 0; k < 2; k++)
      begin
         lfsr_state = lfsr(lfsr_state);
         a = {lfsr_state[6:2], (k == 0) ? 2'b01 : 2'b11};
         u_host.send_byte(1'b0, {tws_pkg::DEV_ADDR, tws_pkg::TT_WRITE});
         u_host.send_byte(1'b1, rev8({1'b1, a}));
         u_host.send_byte(1'b0, {tws_pkg::DEV_ADDR, tws_pkg::TT_READ});
         u_host.recv_byte(e);
         u_host.recv_byte(h);
         u_host.recv_byte(l);
         check(23'(e), 23'(rev8({k == 1, a})), "echo");
         check(23'(h), 23'(rev8(mem[a][15:8])), "data high");
         check(23'(l), 23'(rev8(mem[a][7:0])), "data low");
         drain("read");
      end
      // Strap high blocks the port
      control_style_select = 1'b1;
      repeat (10) @(posedge clock);
      #1;
      write_reg(tws_pkg::DEV_ADDR, tws_pkg::TT_WRITE, 7'h33, 16'h5555);
      control_style_select = 1'b0;
      drain("strap");
      // Extra byte after a write must not start a second write
      exp_q.push_back({7'h22, 16'hbeef});
      write_reg(tws_pkg::DEV_ADDR, tws_pkg::TT_WRITE, 7'h22, 16'hbeef);
      u_host.send_byte(1'b1, 8'h5a);
      drain("no advance");
      results();
   end
endmodule

/* tb/tws_host.sv */
/*
 Holds the host model: it drives the link clock, mode and data lines.
 Assumes the bench resolves the shared data line and calls these tasks.
*/
`timescale 1ns/1ps
module tws_host (
   // System
   input  wire logic clock,
   // Link pins from the host
   output logic      ctrl_clock_line,
   output logic      ctrl_mode_line,
   output logic      host_data,
   output logic      host_drive,
   // Resolved data line
   input  wire logic data_line
);
   // Idle: link clock low, host driving
   initial
   begin
      ctrl_clock_line = 1'b0;
      ctrl_mode_line  = 1'b0;
      host_data       = 1'b0;
      host_drive      = 1'b1;
   end

   // Half of the 160 ns link period, launched just after a system edge
   task automatic half();
      repeat (16) @(posedge clock);
      #1;
   endtask

   // Change after fall, sample on rise
   task automatic pulse(output logic seen);
      half();
      ctrl_clock_line = 1'b1;
      seen            = data_line;
      half();
      ctrl_clock_line = 1'b0;
   endtask

   // One wake pulse, mode high so the next mode edge drops it
   task automatic wake();
      logic dummy;
      ctrl_mode_line = 1'b1;
      pulse(dummy);
   endtask

   // Byte out, bit 0 first, mode held throughout
   task automatic send_byte(input logic mode, input logic [7:0] b);
      logic dummy;
      ctrl_mode_line = mode;
      host_drive     = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         host_data = b[i];
         pulse(dummy);
      end
   endtask

   // Byte in, line released by the host
   task automatic recv_byte(output logic [7:0] b);
      host_drive     = 1'b0;
      ctrl_mode_line = 1'b1;
      for (int i = 0; i < 8; i++)
         pulse(b[i]);
   endtask
endmodule
